// *** rtl/smpc_pkg.sv ***
// Constants, register map and state encoding of the stop-mode power controller.
// Assumes a 100 MHz system clock and a 32-bit Avalon-MM register port.
package smpc_pkg;
	localparam int unsigned ADDR_W = 4;
	localparam logic [3:0] OFF_CTRL = 4'h0;
	localparam logic [3:0] OFF_STATUS = 4'h4;
	localparam logic [3:0] OFF_IRQ_STAT = 4'h8;
	localparam logic [3:0] OFF_IRQ_MASK = 4'hc;
	localparam int unsigned CTRL_W = 10;
	localparam int unsigned B_STOP_EN = 0;
	localparam int unsigned B_DEEP_SEL = 1;
	localparam int unsigned B_MON_EN = 2;
	localparam int unsigned B_MON_STOP_EN = 3;
	localparam int unsigned B_DBG_EN = 4;
	localparam int unsigned B_MON_RST_SEL = 5;
	localparam int unsigned B_OSC_SHALLOW = 6;
	localparam int unsigned B_CONV_ASYNC = 7;
	localparam int unsigned B_TIMER_STOP = 8;
	localparam int unsigned B_RELEASE_ACK = 9;
	localparam logic [9:0] CTRL_RST = 10'h000;
	localparam int unsigned IRQ_W = 3;
	localparam int unsigned I_LOW_SUPPLY = 0;
	localparam int unsigned I_STOP_ENTER = 1;
	localparam int unsigned I_DEEP_WAKE = 2;
	localparam logic [2:0] IRQ_RST = 3'h0;
	localparam logic [15:0] DP_LO = 16'h0000;
	localparam logic [15:0] DP_HI = 16'h005f;
	localparam logic [15:0] HP_LO = 16'h1800;
	localparam logic [15:0] HP_HI = 16'h184f;
	localparam logic [15:0] NV_LO = 16'hffb0;
	localparam logic [15:0] NV_HI = 16'hffbf;
	localparam logic [15:0] UV_LO = 16'hffc0;
	localparam logic [15:0] UV_HI = 16'hffcf;
	typedef enum logic [3:0] {
		ST_RUN = 4'h1,
		ST_SHALLOW = 4'h2,
		ST_DEEP = 4'h4,
		ST_RESTORE = 4'h8
	} smpc_state_t;
endpackage : smpc_pkg

// *** rtl/smpc_top.sv ***
// Stop-mode power controller: picks deep or shallow stop and gates clocks and power.
// Assumes a synchronous stop strobe from the core and Avalon-MM register access.
//
// Implementation choices: the placing of the registers and the Avalon-MM slave port.
`timescale 1ns/10ps
`default_nettype none
module smpc_top
	import smpc_pkg::*;
(
	input wire logic ref_clk,
	input wire logic rst_n,
	input wire logic [smpc_pkg::ADDR_W-1:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	input wire logic [3:0] avs_byteenable,
	output logic [31:0] avs_readdata,
	output logic avs_waitrequest,
	input wire logic stop_exec,
	input wire logic wake_irq,
	input wire logic wake_pin,
	input wire logic supply_low,
	input wire logic [15:0] cpu_addr,
	output logic periph_clk_en,
	output logic debug_clk_en,
	output logic osc_en,
	output logic regulator_active,
	output logic conv_en,
	output logic wake_timer_en,
	output logic core_power_on,
	output logic core_standby,
	output logic pin_hold,
	output logic cpu_resume,
	output logic illegal_op_rst,
	output logic supply_rst,
	output logic deep_wake_rst,
	output logic dp_sel,
	output logic hp_sel,
	output logic nv_sel,
	output logic user_vec_sel,
	output logic irq
);
	import smpc_pkg::*;

	typedef struct packed {
		smpc_state_t st;
		logic [CTRL_W-1:0] ctrl;
		logic dbg;
		logic wake_flag;
		logic hold;
		logic low_prev;
		logic [IRQ_W-1:0] ist;
		logic [IRQ_W-1:0] imask;
		logic ack;
		logic [31:0] rdata;
		logic clk_p;
		logic dclk;
		logic osc;
		logic reg_on;
		logic conv;
		logic tmr;
		logic pwr;
		logic stby;
		logic pins;
		logic resume;
		logic ill_rst;
		logic sup_rst;
		logic dw_rst;
		logic dp;
		logic hp;
		logic nv;
		logic uv;
	} smpc_regs_t;

	smpc_regs_t r_q;
	smpc_regs_t r_d;
	logic [1:0] rst_sync_q;
	logic srst_n;

	// Reset is released through two flops so every flop of r_q leaves reset on the same edge.
	always_ff @(posedge ref_clk or negedge rst_n)
	begin
		if (!rst_n)
			rst_sync_q <= 2'h0;
		else
			rst_sync_q <= {rst_sync_q[0], 1'b1};
	end
	assign srst_n = rst_sync_q[1];

	logic access;
	logic wr_now;
	logic mon_stop;
	logic low_event;
	logic go_deep;
	logic [31:0] wmask;
	assign access = avs_read | avs_write;
	// The first cycle of each access is a wait state so read data can come from a flop.
	assign avs_waitrequest = access & ~r_q.ack;
	assign wr_now = avs_write & r_q.ack;
	assign wmask = {{8{avs_byteenable[3]}}, {8{avs_byteenable[2]}},
		{8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};
	assign mon_stop = r_q.ctrl[B_MON_EN] & r_q.ctrl[B_MON_STOP_EN];
	// The detector only watches in stop when enabled for it; in run it needs only its enable.
	assign low_event = supply_low & ~r_q.low_prev & r_q.ctrl[B_MON_EN]
		& (r_q.st == ST_RUN || r_q.st == ST_RESTORE || mon_stop);
	// Either override demotes a deep stop request to shallow stop.
	assign go_deep = r_q.ctrl[B_DEEP_SEL] & ~mon_stop & ~r_q.ctrl[B_DBG_EN];

	always_comb
	begin
		logic [31:0] ctrl_w;
		logic stopped;
		ctrl_w = 32'h0;
		stopped = 1'b0;
		r_d = r_q;
		r_d.ack = access & ~r_q.ack;
		r_d.low_prev = supply_low;
		r_d.resume = 1'b0;
		r_d.ill_rst = 1'b0;
		r_d.sup_rst = 1'b0;
		r_d.dw_rst = 1'b0;
		if (wr_now)
		begin
			case (avs_address)
				OFF_CTRL:
				begin
					ctrl_w = (32'(r_q.ctrl) & ~wmask) | (avs_writedata & wmask);
					r_d.ctrl = ctrl_w[CTRL_W-1:0];
					r_d.ctrl[B_RELEASE_ACK] = 1'b0;
					if (ctrl_w[B_RELEASE_ACK])
					begin
						r_d.wake_flag = 1'b0;
						r_d.hold = 1'b0;
					end
				end
				OFF_IRQ_STAT: r_d.ist = r_q.ist & ~(avs_writedata[IRQ_W-1:0] & wmask[IRQ_W-1:0]);
				OFF_IRQ_MASK: r_d.imask = (r_q.imask & ~wmask[IRQ_W-1:0])
					| (avs_writedata[IRQ_W-1:0] & wmask[IRQ_W-1:0]);
				default: r_d.imask = r_q.imask;
			endcase
		end
		if (low_event)
		begin
			if (r_q.ctrl[B_MON_RST_SEL])
				r_d.sup_rst = 1'b1;
			else
				r_d.ist[I_LOW_SUPPLY] = 1'b1;
		end
		case (r_q.st)
			ST_RUN:
			begin
				if (stop_exec)
				begin
					if (!r_q.ctrl[B_STOP_EN])
						r_d.ill_rst = 1'b1;
					else
					begin
						r_d.dbg = r_q.ctrl[B_DBG_EN];
						r_d.st = go_deep ? ST_DEEP : ST_SHALLOW;
						r_d.ist[I_STOP_ENTER] = 1'b1;
					end
				end
			end
			ST_SHALLOW:
			begin
				if (wake_irq || (low_event && !r_q.ctrl[B_MON_RST_SEL]))
					r_d.st = ST_RESTORE;
				else if (low_event)
					r_d.st = ST_RUN;
			end
			ST_DEEP:
			begin
				if (wake_pin)
				begin
					r_d.st = ST_RUN;
					r_d.wake_flag = 1'b1;
					r_d.hold = 1'b1;
					r_d.dw_rst = 1'b1;
					r_d.ist[I_DEEP_WAKE] = 1'b1;
				end
			end
			ST_RESTORE:
			begin
				r_d.st = ST_RUN;
				r_d.resume = 1'b1;
			end
			default: r_d.st = ST_RUN;
		endcase
		stopped = (r_d.st == ST_SHALLOW) || (r_d.st == ST_DEEP);
		r_d.clk_p = ~stopped;
		r_d.dclk = ~stopped | (r_d.dbg & (r_d.st == ST_SHALLOW));
		r_d.osc = ~stopped | ((r_d.st == ST_SHALLOW) & (r_d.dbg | r_q.ctrl[B_OSC_SHALLOW]));
		r_d.reg_on = ~stopped | r_d.dbg | mon_stop;
		r_d.conv = ~stopped | ((r_d.st == ST_SHALLOW) & r_q.ctrl[B_CONV_ASYNC]
			& r_q.ctrl[B_MON_EN]);
		r_d.tmr = ~stopped | r_q.ctrl[B_TIMER_STOP];
		r_d.pwr = (r_d.st != ST_DEEP);
		r_d.stby = (r_d.st == ST_SHALLOW);
		r_d.pins = stopped | r_d.hold;
		r_d.dp = (cpu_addr >= DP_LO) && (cpu_addr <= DP_HI);
		r_d.hp = (cpu_addr >= HP_LO) && (cpu_addr <= HP_HI);
		r_d.nv = (cpu_addr >= NV_LO) && (cpu_addr <= NV_HI);
		r_d.uv = (cpu_addr >= UV_LO) && (cpu_addr <= UV_HI);
		r_d.rdata = r_q.rdata;
		if (avs_read && !r_q.ack)
		begin
			case (avs_address)
				OFF_CTRL: r_d.rdata = 32'(r_q.ctrl);
				OFF_STATUS: r_d.rdata = {24'h0, r_q.st, r_q.dbg, r_q.hold, r_q.wake_flag, go_deep};
				OFF_IRQ_STAT: r_d.rdata = 32'(r_q.ist);
				OFF_IRQ_MASK: r_d.rdata = 32'(r_q.imask);
				default: r_d.rdata = 32'h0;
			endcase
		end
	end

	always_ff @(posedge ref_clk or negedge srst_n)
	begin
		if (!srst_n)
		begin
			r_q <= '0;
			r_q.st <= ST_RUN;
			r_q.ctrl <= CTRL_RST;
			r_q.ist <= IRQ_RST;
			r_q.imask <= IRQ_RST;
			r_q.clk_p <= 1'b1;
			r_q.dclk <= 1'b1;
			r_q.osc <= 1'b1;
			r_q.reg_on <= 1'b1;
			r_q.conv <= 1'b1;
			r_q.tmr <= 1'b1;
			r_q.pwr <= 1'b1;
		end
		else
			r_q <= r_d;
	end

	assign avs_readdata = r_q.rdata;
	assign periph_clk_en = r_q.clk_p;
	assign debug_clk_en = r_q.dclk;
	assign osc_en = r_q.osc;
	assign regulator_active = r_q.reg_on;
	assign conv_en = r_q.conv;
	assign wake_timer_en = r_q.tmr;
	assign core_power_on = r_q.pwr;
	assign core_standby = r_q.stby;
	assign pin_hold = r_q.pins;
	assign cpu_resume = r_q.resume;
	assign illegal_op_rst = r_q.ill_rst;
	assign supply_rst = r_q.sup_rst;
	assign deep_wake_rst = r_q.dw_rst;
	assign dp_sel = r_q.dp;
	assign hp_sel = r_q.hp;
	assign nv_sel = r_q.nv;
	assign user_vec_sel = r_q.uv;
	// A level output keeps the line high until software clears every unmasked source.
	assign irq = |(r_q.ist & r_q.imask);

	default clocking cb @(posedge ref_clk);
	endclocking
	default disable iff (!srst_n);

	a_stop_illegal: assert property ((r_q.st == ST_RUN) && stop_exec
		&& !r_q.ctrl[B_STOP_EN] |=> illegal_op_rst && (r_q.st == ST_RUN))
		else $error("stop without enable not trapped");
	a_stop_refused: assert property ((r_q.st != ST_RUN)
		|=> !illegal_op_rst)
		else $error("illegal reset outside run");
	a_debug_shallow: assert property ((r_q.st == ST_RUN) && stop_exec
		&& r_q.ctrl[B_STOP_EN] && r_q.ctrl[B_DBG_EN]
		|=> (r_q.st == ST_SHALLOW) && osc_en && regulator_active)
		else $error("debug stop not shallow");
	a_debug_keep: assert property ((r_q.st == ST_SHALLOW) && r_q.dbg
		|-> osc_en && regulator_active && debug_clk_en)
		else $error("debug stop lost clock or regulator");
	a_monitor_demote: assert property ((r_q.st == ST_RUN) && stop_exec
		&& r_q.ctrl[B_STOP_EN] && mon_stop
		|=> (r_q.st == ST_SHALLOW) && regulator_active)
		else $error("monitor stop not shallow");
	a_monitor_reg: assert property ((r_q.st == ST_SHALLOW) && $stable(r_q.st)
		&& $past(mon_stop) |-> regulator_active)
		else $error("regulator idle with monitor in stop");
	a_osc_shallow: assert property ((r_q.st == ST_SHALLOW) && $stable(r_q.st)
		&& !r_q.dbg && !$past(r_q.ctrl[B_OSC_SHALLOW]) |-> !osc_en)
		else $error("clock source runs in shallow stop");
	a_deep_select: assert property ((r_q.st == ST_RUN) && stop_exec
		&& r_q.ctrl[B_STOP_EN] && go_deep
		|=> (r_q.st == ST_DEEP) && !core_power_on && pin_hold)
		else $error("deep stop not entered");
	a_deep_power: assert property ((r_q.st == ST_DEEP)
		|-> !core_power_on && !core_standby && pin_hold && !osc_en && !conv_en)
		else $error("deep stop power state wrong");
	a_shallow_standby: assert property ((r_q.st == ST_SHALLOW)
		|-> core_power_on && core_standby && pin_hold)
		else $error("shallow stop standby wrong");
	a_periph_clk_off: assert property ((r_q.st == ST_SHALLOW || r_q.st == ST_DEEP)
		|-> !periph_clk_en)
		else $error("peripheral clock runs in stop");
	a_debug_clk_run: assert property ((r_q.st == ST_SHALLOW) && r_q.dbg
		&& $stable(r_q.st) |-> debug_clk_en && !periph_clk_en)
		else $error("debug clock stopped");
	a_conv_gate: assert property ((r_q.st == ST_SHALLOW) && $stable(r_q.st) && conv_en
		|-> $past(r_q.ctrl[B_CONV_ASYNC]) && $past(r_q.ctrl[B_MON_EN]))
		else $error("converter runs ungated");
	a_wake_resume: assert property ((r_q.st == ST_SHALLOW) && wake_irq
		|=> periph_clk_en && !cpu_resume ##1 cpu_resume)
		else $error("resume before clocks");
	a_hold_latched: assert property ((r_q.st == ST_DEEP) && wake_pin
		|=> r_q.wake_flag && pin_hold && deep_wake_rst)
		else $error("deep wake not latched");
	a_flag_sticky: assert property (r_q.wake_flag && !wr_now
		|=> r_q.wake_flag && pin_hold)
		else $error("wake flag or pin latch dropped");
	a_supply_reset: assert property (low_event && r_q.ctrl[B_MON_RST_SEL]
		|=> supply_rst)
		else $error("low supply reset missing");
	a_supply_irq: assert property (low_event && !r_q.ctrl[B_MON_RST_SEL]
		|=> r_q.ist[I_LOW_SUPPLY])
		else $error("low supply event not flagged");
	a_direct_page: assert property ((cpu_addr == DP_HI)
		|=> dp_sel && !hp_sel && !user_vec_sel)
		else $error("direct page decode wrong");
	a_page_decode: assert property ((cpu_addr == HP_HI)
		|=> hp_sel && !dp_sel && !nv_sel)
		else $error("high page decode wrong");
	a_nv_page: assert property ((cpu_addr == NV_HI)
		|=> nv_sel && !user_vec_sel && !hp_sel)
		else $error("non-volatile decode wrong");
	a_user_vector: assert property ((cpu_addr == UV_LO)
		|=> user_vec_sel && !nv_sel)
		else $error("vector space decode wrong");
endmodule : smpc_top
`default_nettype wire

// *** test/stop_mode_power_control_bench.sv ***
// Self-checking bench for the stop-mode power controller.
// Assumes smpc_pkg and smpc_top are compiled first; the bench drives every port itself.
`timescale 1ns/10ps
`default_nettype none
module stop_mode_power_control_bench;
	import smpc_pkg::*;
	logic ref_clk = 1'b0;
	logic rst_n = 1'b0;
	logic [3:0] avs_address = 4'h0;
	logic avs_read = 1'b0;
	logic avs_write = 1'b0;
	logic [31:0] avs_writedata = 32'h0;
	logic [3:0] avs_byteenable = 4'hf;
	logic [31:0] avs_readdata;
	logic avs_waitrequest, stop_exec = 1'b0, wake_irq = 1'b0, wake_pin = 1'b0;
	logic supply_low = 1'b0;
	logic [15:0] cpu_addr = 16'h0;
	logic periph_clk_en, debug_clk_en, osc_en, regulator_active, conv_en, wake_timer_en;
	logic core_power_on, core_standby, pin_hold, cpu_resume, illegal_op_rst, supply_rst;
	logic deep_wake_rst, dp_sel, hp_sel, nv_sel, user_vec_sel, irq;
	int num_errors = 0;
	int total_checks = 0;
	logic [15:0] da [12] = '{16'h0000, 16'h005f, 16'h0060, 16'h1800, 16'h184f, 16'h1850,
		16'hffaf, 16'hffb0, 16'hffbf, 16'hffc0, 16'hffcf, 16'hffd0};
	logic [3:0] dx [12] = '{4'h8, 4'h8, 4'h0, 4'h4, 4'h4, 4'h0, 4'h0, 4'h2, 4'h2, 4'h1, 4'h1, 4'h0};
	logic [3:0] ra [5] = '{OFF_CTRL, OFF_STATUS, OFF_IRQ_STAT, OFF_IRQ_MASK, 4'h2};
	logic [31:0] re [5] = '{32'h0, 32'h10, 32'h0, 32'h0, 32'h0};
	logic [31:0] cm [5] = '{32'h001, 32'h08f, 32'h013, 32'h101, 32'h041};
	logic [8:0] eg [5] = '{9'h007, 9'h037, 9'h0e7, 9'h00f, 9'h047};
	// Gating outputs packed so one compare covers a whole power state.
	wire [8:0] gate = {periph_clk_en, debug_clk_en, osc_en, regulator_active, conv_en,
		wake_timer_en, core_power_on, core_standby, pin_hold};
	wire [3:0] sel = {dp_sel, hp_sel, nv_sel, user_vec_sel};
	wire [3:0] pul = {cpu_resume, illegal_op_rst, supply_rst, deep_wake_rst};

	smpc_top i_smpc_top (.ref_clk, .rst_n, .avs_address, .avs_read, .avs_write,
		.avs_writedata, .avs_byteenable, .avs_readdata, .avs_waitrequest, .stop_exec,
		.wake_irq, .wake_pin, .supply_low, .cpu_addr, .periph_clk_en, .debug_clk_en,
		.osc_en, .regulator_active, .conv_en, .wake_timer_en, .core_power_on,
		.core_standby, .pin_hold, .cpu_resume, .illegal_op_rst, .supply_rst,
		.deep_wake_rst, .dp_sel, .hp_sel, .nv_sel, .user_vec_sel, .irq);

	initial
	begin
		forever #5 ref_clk = ~ref_clk;
	end

	task automatic end_sim();
		$display("checks %0d errors %0d", total_checks, num_errors);
		if (num_errors == 0 && total_checks > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask : end_sim

	task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
		total_checks++;
		if (s !== e)
		begin
			num_errors++;
			$display("ERROR %s expected %h seen %h", n, e, s);
		end
	endtask : chk

	// Request stays up until a rising edge samples waitrequest low; data is taken there.
	task automatic acc(input logic w, input logic [3:0] a, input logic [31:0] d,
		input logic [3:0] be, output logic [31:0] r);
		int n;
		n = 0;
		@(posedge ref_clk);
		avs_address <= a;
		avs_write <= w;
		avs_read <= !w;
		avs_writedata <= d;
		avs_byteenable <= be;
		@(posedge ref_clk);
		while (avs_waitrequest !== 1'b0 && n < 50)
		begin
			@(posedge ref_clk);
			n++;
		end
		if (n >= 50)
		begin
			num_errors++;
			end_sim();
		end
		r = avs_readdata;
		avs_read <= 1'b0;
		avs_write <= 1'b0;
	endtask : acc

	task automatic wr(input logic [3:0] a, input logic [31:0] d);
		logic [31:0] r;
		acc(1'b1, a, d, 4'hf, r);
	endtask : wr

	task automatic rchk(input logic [3:0] a, input logic [31:0] e);
		logic [31:0] r;
		acc(1'b0, a, 32'h0, 4'hf, r);
		chk("readdata", r, e);
	endtask : rchk

	// One-cycle event on stop, wake and supply inputs, then look at the settled result.
	task automatic step(input logic [3:0] v);
		@(posedge ref_clk);
		{stop_exec, wake_irq, wake_pin, supply_low} <= v;
		@(posedge ref_clk);
		{stop_exec, wake_irq, wake_pin, supply_low} <= 4'h0;
		@(negedge ref_clk);
	endtask : step

	initial
	begin
		logic [31:0] r;
		repeat (12) @(posedge ref_clk);
		rst_n <= 1'b1;
		repeat (4) @(posedge ref_clk);
		chk("gate", gate, 9'h1fc);
		for (int i = 0; i < 5; i++)
			rchk(ra[i], re[i]);
		acc(1'b1, OFF_CTRL, 32'hffffffff, 4'h2, r);
		rchk(OFF_CTRL, 32'h100);
		wr(OFF_CTRL, 32'h0);
		$display("test reset and registers done");
		for (int i = 0; i < 12; i++)
		begin
			@(posedge ref_clk);
			cpu_addr <= da[i];
			@(posedge ref_clk);
			@(negedge ref_clk);
			chk("decode", sel, dx[i]);
		end
		$display("test decode done");
		step(4'h8);
		chk("pulses", pul, 4'h4);
		chk("gate", gate, 9'h1fc);
		$display("test refused stop done");
		for (int i = 0; i < 5; i++)
		begin
			wr(OFF_CTRL, cm[i]);
			step(4'h8);
			chk("gate", gate, eg[i]);
			step(4'h4);
			chk("gate", gate, 9'h1fc);
			chk("pulses", pul, 4'h0);
			@(negedge ref_clk);
			chk("pulses", pul, 4'h8);
		end
		$display("test shallow stop done");
		wr(OFF_CTRL, 32'h003);
		step(4'h8);
		chk("gate", gate, 9'h001);
		step(4'h2);
		chk("pulses", pul, 4'h1);
		chk("gate", gate, 9'h1fd);
		rchk(OFF_STATUS, 32'h17);
		wr(OFF_CTRL, 32'h203);
		rchk(OFF_STATUS, 32'h11);
		chk("gate", gate, 9'h1fc);
		wr(OFF_IRQ_MASK, 32'h4);
		repeat (2) @(negedge ref_clk);
		chk("irq", irq, 1'b1);
		wr(OFF_IRQ_STAT, 32'h7);
		rchk(OFF_IRQ_STAT, 32'h0);
		chk("irq", irq, 1'b0);
		$display("test deep stop done");
		wr(OFF_IRQ_MASK, 32'h1);
		wr(OFF_CTRL, 32'h004);
		step(4'h1);
		rchk(OFF_IRQ_STAT, 32'h1);
		chk("irq", irq, 1'b1);
		wr(OFF_CTRL, 32'h024);
		step(4'h1);
		chk("pulses", pul, 4'h2);
		$display("test supply monitor done");
		end_sim();
	end
endmodule : stop_mode_power_control_bench
`default_nettype wire
